// ### rtl/ppp_cfg.svh
// constants for the parallel flash programming port
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
`define PPP_SEL_ADDR 2'h0
`define PPP_SEL_DATA 2'h1
`define PPP_SEL_CMD 2'h2
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WRFLASH 8'h10
`define PPP_PAGE_WORDS 32
`define PPP_PAGE_AW 5
`define PPP_EE_BYTES 16
`define PPP_EE_AW 4
`define PPP_ERASE_CYC 16'h0040
`define PPP_WRITE_CYC 16'h0020
`define PPP_ERASED_WORD 16'hFFFF
`define PPP_ERASED_BYTE 8'hFF
`define PPP_EE_INIT 8'hA5
`define PPP_CLK_DIV 5'h10
`define PPP_STEP_CYC 6'h20
`endif

// ### rtl/ppp_pkg.sv
// types shared by both ends of the programming port
package ppp_pkg;
    typedef enum logic [2:0] {
        PPP_OP_CMD,
        PPP_OP_ADDR,
        PPP_OP_DLO,
        PPP_OP_DHI,
        PPP_OP_LATCH,
        PPP_OP_WRITE
    } ppp_op_t;
endpackage

// ### rtl/ppp_if.sv
// pins between programmer and device
`timescale 1ns/1ps
`default_nettype none
interface ppp_if;
    logic load_select_hi;
    logic load_select_lo;
    logic byte_select;
    logic crystal_input_strobe;
    logic page_latch_strobe;
    logic write_strobe_n;
    logic [7:0] dataBus;
    logic ready_busy_out;
    modport device (
        input load_select_hi, load_select_lo, byte_select,
        input crystal_input_strobe, page_latch_strobe, write_strobe_n,
        input dataBus,
        output ready_busy_out
    );
    modport programmer (
        output load_select_hi, load_select_lo, byte_select,
        output crystal_input_strobe, page_latch_strobe, write_strobe_n,
        output dataBus,
        input ready_busy_out
    );
endinterface
`default_nettype wire

// ### rtl/ppp_device.sv
// device end: decodes strobes, page buffer, erase and page write
// Notes on behaviour
// - select 10, byte 0, strobe loads command
// - byte 80h means chip erase
// - write low pulse starts erase, busy low
// - programmer waits ready before next command
// - preserve fuse keeps eeprom during erase
// - byte 10h means write flash session
// - select 00, byte 0 loads address low
// - select 01, byte 0 loads data low byte
// - select 01, byte 1 loads data high
// - page latch with byte 1 buffers word
// - whole page programmed at once
`timescale 1ns/1ps
`default_nettype none
`include "ppp_cfg.svh"
module ppp_device
    import ppp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // programming pins
    ppp_if.device pins,
    // fuse and memory peek
    input wire logic eeprom_preserve_fuse,
    input wire logic [`PPP_PAGE_AW-1:0] peekAddr,
    output logic [15:0] peekFlash,
    output logic [7:0] peekEeprom,
    output logic [7:0] commandReg,
    output logic [7:0] addrLow
);
    // three-stage synchronisers for pins
    logic [2:0] xs, ps, ws;
    logic [2:0] sels [0:2];
    logic [7:0] ds [0:2];
    logic [2:0] next_xs, next_ps, next_ws;
    always_comb begin
        next_xs = {xs[1:0], pins.crystal_input_strobe};
        next_ps = {ps[1:0], pins.page_latch_strobe};
        next_ws = {ws[1:0], pins.write_strobe_n};
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            xs <= 3'h0;
            ps <= 3'h0;
            ws <= 3'h7;
            for (int i = 0; i < 3; i++) begin
                sels[i] <= 3'h0;
                ds[i] <= 8'h00;
            end
        end else begin
            xs <= next_xs;
            ps <= next_ps;
            ws <= next_ws;
            sels[0] <= {pins.load_select_hi, pins.load_select_lo,
                pins.byte_select};
            ds[0] <= pins.dataBus;
            for (int i = 1; i < 3; i++) begin
                sels[i] <= sels[i-1];
                ds[i] <= ds[i-1];
            end
        end
    end
    // filtered level: a change counts once stages two and three agree
    function automatic logic settle(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) ? s[2] : lvl;
    endfunction
    logic xLvl, pLvl, wLvl, next_xLvl, next_pLvl, next_wLvl;
    logic xRise, pRise, wFall;
    always_comb begin
        next_xLvl = settle(xs, xLvl);
        next_pLvl = settle(ps, pLvl);
        next_wLvl = settle(ws, wLvl);
        xRise = next_xLvl & ~xLvl;
        pRise = next_pLvl & ~pLvl;
        wFall = ~next_wLvl & wLvl;
    end
    // filtered levels start at the idle level of each pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            xLvl <= 1'b0;
            pLvl <= 1'b0;
            wLvl <= 1'b1; // write strobe idles high
        end else begin
            xLvl <= next_xLvl;
            pLvl <= next_pLvl;
            wLvl <= next_wLvl;
        end
    end

    typedef enum logic [1:0] {PPP_IDLE, PPP_ERASE, PPP_PROG} ppp_dst_t;
    ppp_dst_t state, next_state;
    logic [7:0] next_commandReg, next_addrLow, dataLo, dataHi;
    logic [7:0] next_dataLo, next_dataHi;
    logic [15:0] timer, next_timer;
    logic [`PPP_PAGE_AW-1:0] fillIdx, next_fillIdx, progIdx, next_progIdx;
    logic [15:0] pageBuf [0:`PPP_PAGE_WORDS-1];
    logic [15:0] flashMem [0:`PPP_PAGE_WORDS-1];
    logic [7:0] eeMem [0:`PPP_EE_BYTES-1];
    logic [1:0] sel;
    logic bsel;
    logic latchHit;
    always_comb begin
        sel = sels[2][2:1];
        bsel = sels[2][0];
        latchHit = (state == PPP_IDLE) && pRise && bsel &&
            (commandReg == `PPP_CMD_WRFLASH);
    end

    // command, address, data decode and sequencing
    always_comb begin
        next_state = state;
        next_commandReg = commandReg;
        next_addrLow = addrLow;
        next_dataLo = dataLo;
        next_dataHi = dataHi;
        next_timer = timer;
        next_fillIdx = fillIdx;
        next_progIdx = progIdx;
        case (state)
            PPP_IDLE: begin
                if (xRise) begin
                    if (sel == `PPP_SEL_CMD && !bsel) begin
                        next_commandReg = ds[2];
                        next_fillIdx = '0;
                    end else if (sel == `PPP_SEL_ADDR && !bsel) begin
                        next_addrLow = ds[2];
                        next_fillIdx = ds[2][`PPP_PAGE_AW-1:0];
                    end else if (sel == `PPP_SEL_DATA && !bsel) begin
                        next_dataLo = ds[2];
                    end else if (sel == `PPP_SEL_DATA && bsel) begin
                        next_dataHi = ds[2];
                    end
                end
                if (latchHit) begin
                    next_fillIdx = fillIdx + 1'b1;
                end
                if (wFall) begin
                    if (commandReg == `PPP_CMD_ERASE) begin
                        next_state = PPP_ERASE;
                        next_timer = `PPP_ERASE_CYC;
                    end else if (commandReg == `PPP_CMD_WRFLASH) begin
                        next_state = PPP_PROG;
                        next_timer = `PPP_WRITE_CYC;
                        next_progIdx = '0;
                    end
                end
            end
            PPP_ERASE, PPP_PROG: begin
                next_progIdx = progIdx + 1'b1;
                next_timer = timer - 16'h0001;
                if (timer == 16'h0001) begin
                    next_state = PPP_IDLE;
                end
            end
            default: next_state = PPP_IDLE;
        endcase
    end
    // state registers and memories
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= PPP_IDLE;
            commandReg <= 8'h00;
            addrLow <= 8'h00;
            dataLo <= 8'h00;
            dataHi <= 8'h00;
            timer <= 16'h0000;
            fillIdx <= '0;
            progIdx <= '0;
        end else begin
            state <= next_state;
            commandReg <= next_commandReg;
            addrLow <= next_addrLow;
            dataLo <= next_dataLo;
            dataHi <= next_dataHi;
            timer <= next_timer;
            fillIdx <= next_fillIdx;
            progIdx <= next_progIdx;
        end
    end
    // page buffer, flash array and eeprom contents
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int k = 0; k < `PPP_EE_BYTES; k++) begin
                eeMem[k] <= `PPP_EE_INIT; // stand-in for stored data
            end
        end else begin
            if (latchHit) begin
                pageBuf[fillIdx] <= {dataHi, dataLo};
            end
            if (state == PPP_PROG) begin
                flashMem[progIdx] <= pageBuf[progIdx];
            end
            if (state == PPP_ERASE) begin
                // whole arrays each cycle, erase is longer than the page
                for (int k = 0; k < `PPP_PAGE_WORDS; k++) begin
                    flashMem[k] <= `PPP_ERASED_WORD;
                    pageBuf[k] <= `PPP_ERASED_WORD;
                end
                if (!eeprom_preserve_fuse) begin
                    for (int k = 0; k < `PPP_EE_BYTES; k++) begin
                        eeMem[k] <= `PPP_ERASED_BYTE;
                    end
                end
            end
        end
    end
    // busy while erase or page write runs
    always_comb begin
        pins.ready_busy_out = (state == PPP_IDLE);
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            peekFlash <= 16'h0000;
            peekEeprom <= 8'h00;
        end else begin
            peekFlash <= flashMem[peekAddr];
            peekEeprom <= eeMem[peekAddr[`PPP_EE_AW-1:0]];
        end
    end
endmodule
`default_nettype wire

// ### rtl/ppp_programmer.sv
// programmer end: drives pins one step at a time
`timescale 1ns/1ps
`default_nettype none
`include "ppp_cfg.svh"
module ppp_programmer
    import ppp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // programming pins
    ppp_if.programmer pins,
    // user request
    input wire logic opValid,
    input wire ppp_op_t opKind,
    input wire logic [7:0] opData,
    output logic opReady
);
    typedef enum logic [1:0] {PPP_P_IDLE, PPP_P_SETUP, PPP_P_PULSE,
        PPP_P_HOLD} ppp_pst_t;
    ppp_pst_t state, next_state;
    ppp_op_t op, next_op;
    logic [7:0] data, next_data;
    logic [5:0] cnt, next_cnt;
    logic [2:0] rb, next_rb;
    logic rdy, next_rdy;
    // ready pin synchroniser, counts once stages two and three agree
    always_comb begin
        next_rb = {rb[1:0], pins.ready_busy_out};
        next_rdy = (rb[1] == rb[2]) ? rb[2] : rdy;
    end
    // step sequencing
    always_comb begin
        next_state = state;
        next_op = op;
        next_data = data;
        next_cnt = cnt;
        case (state)
            PPP_P_IDLE: begin
                if (opValid && rdy) begin
                    next_op = opKind;
                    next_data = opData;
                    next_state = PPP_P_SETUP;
                    next_cnt = `PPP_STEP_CYC;
                end
            end
            default: begin
                next_cnt = cnt - 6'h01;
                if (cnt == 6'h01) begin
                    next_cnt = `PPP_STEP_CYC;
                    if (state == PPP_P_SETUP) next_state = PPP_P_PULSE;
                    else if (state == PPP_P_PULSE) next_state = PPP_P_HOLD;
                    else next_state = PPP_P_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= PPP_P_IDLE;
            op <= PPP_OP_CMD;
            data <= 8'h00;
            cnt <= 6'h00;
            rb <= 3'h0;
            rdy <= 1'b0;
        end else begin
            state <= next_state;
            op <= next_op;
            data <= next_data;
            cnt <= next_cnt;
            rb <= next_rb;
            rdy <= next_rdy;
        end
    end
    // pin levels per step
    always_comb begin
        opReady = (state == PPP_P_IDLE) && rdy;
        pins.dataBus = data;
        pins.load_select_hi = (op == PPP_OP_CMD);
        pins.load_select_lo = (op == PPP_OP_DLO) || (op == PPP_OP_DHI);
        pins.byte_select = (op == PPP_OP_DHI) || (op == PPP_OP_LATCH);
        pins.crystal_input_strobe = (state == PPP_P_PULSE) &&
            (op <= PPP_OP_DHI);
        pins.page_latch_strobe = (state == PPP_P_PULSE) &&
            (op == PPP_OP_LATCH);
        pins.write_strobe_n = !((state == PPP_P_PULSE) &&
            (op == PPP_OP_WRITE));
    end
endmodule
`default_nettype wire

// ### tb/ppp_asserts.sv
// concurrent checks on the programming port pins
`timescale 1ns/1ps
`default_nettype none
`include "ppp_cfg.svh"
module ppp_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // port pins
    input wire logic load_select_hi,
    input wire logic load_select_lo,
    input wire logic byte_select,
    input wire logic crystal_input_strobe,
    input wire logic page_latch_strobe,
    input wire logic write_strobe_n,
    input wire logic [7:0] dataBus,
    input wire logic ready_busy_out
);
    logic strobeQ;
    logic [7:0] lastCmd;
    logic [7:0] busyLen;
    logic [7:0] next_lastCmd;
    logic [7:0] next_busyLen;
    logic [15:0] busyCyc;
    // last command byte seen on the pins, busy run length
    always_comb begin
        next_lastCmd = lastCmd;
        if (crystal_input_strobe && !strobeQ && load_select_hi &&
            !load_select_lo && !byte_select) begin
            next_lastCmd = dataBus;
        end
        next_busyLen = ready_busy_out ? 8'h00 : busyLen + 8'h01;
        busyCyc = (lastCmd == `PPP_CMD_ERASE) ? `PPP_ERASE_CYC
                                              : `PPP_WRITE_CYC;
    end
    // register helper state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strobeQ <= 1'b0;
            lastCmd <= 8'h00;
            busyLen <= 8'h00;
        end else begin
            strobeQ <= crystal_input_strobe;
            lastCmd <= next_lastCmd;
            busyLen <= next_busyLen;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence busyStart;
        ##[1:8] !ready_busy_out;
    endsequence
    sequence pinsSteady;
        $stable({load_select_hi, load_select_lo, byte_select, dataBus});
    endsequence
    a_write_goes_busy: assert property ($fell(write_strobe_n) &&
        (lastCmd == `PPP_CMD_ERASE || lastCmd == `PPP_CMD_WRFLASH)
        |-> busyStart) else $error("write strobe gave no busy");
    a_busy_run_len: assert property ($rose(ready_busy_out) |->
        {8'h00, busyLen} >= busyCyc && {8'h00, busyLen} <= busyCyc + 16'h0003)
        else $error("busy length wrong for command");
    a_busy_needs_cmd: assert property ($fell(ready_busy_out) |->
        lastCmd == `PPP_CMD_ERASE || lastCmd == `PPP_CMD_WRFLASH)
        else $error("busy without erase or write command");
    a_busy_needs_wr: assert property ($fell(ready_busy_out) |->
        !write_strobe_n) else $error("busy without write pulse");
    a_no_load_busy: assert property (!ready_busy_out |->
        !$rose(crystal_input_strobe)) else $error("load while busy");
    a_write_on_ready: assert property ($fell(write_strobe_n) |->
        ready_busy_out) else $error("write pulse while busy");
    a_pins_held: assert property (crystal_input_strobe &&
        $past(crystal_input_strobe) |-> pinsSteady)
        else $error("selects or data moved in strobe");
    a_latch_byte_hi: assert property ($rose(page_latch_strobe) |->
        byte_select) else $error("page latch without byte select");
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench joining programmer and device ends
`timescale 1ns/1ps
`default_nettype none
`include "ppp_cfg.svh"
module tb;
    import ppp_pkg::*;
    logic clock;
    logic rst_n;
    logic opValid;
    ppp_op_t opKind;
    logic [7:0] opData;
    logic opReady;
    logic fuseKeep;
    logic [4:0] peekAddr;
    logic [15:0] peekFlash;
    logic [7:0] peekEeprom;
    logic [7:0] commandReg;
    logic [7:0] addrLow;
    logic [15:0] words [0:3];
    logic [4:0] base;
    logic [7:0] eeExp;
    int bad_count;
    int checks;
    int i;
    ppp_if pins ();
    // both ends facing each other
    ppp_programmer u_ppp_programmer (.clock(clock), .rst_n(rst_n),
        .pins(pins), .opValid(opValid), .opKind(opKind),
        .opData(opData), .opReady(opReady));
    ppp_device u_ppp_device (.clock(clock), .rst_n(rst_n), .pins(pins),
        .eeprom_preserve_fuse(fuseKeep), .peekAddr(peekAddr),
        .peekFlash(peekFlash), .peekEeprom(peekEeprom),
        .commandReg(commandReg), .addrLow(addrLow));
    ppp_asserts u_ppp_asserts (.clock(clock), .rst_n(rst_n),
        .load_select_hi(pins.load_select_hi),
        .load_select_lo(pins.load_select_lo),
        .byte_select(pins.byte_select),
        .crystal_input_strobe(pins.crystal_input_strobe),
        .page_latch_strobe(pins.page_latch_strobe),
        .write_strobe_n(pins.write_strobe_n),
        .dataBus(pins.dataBus), .ready_busy_out(pins.ready_busy_out));
    // result reporting
    task automatic fail(input string msg);
        bad_count++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) fail("byte differs");
    endtask
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) fail("word differs");
    endtask
    task automatic report_and_stop();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one programmer step, taken when opReady is seen
    task automatic do_op(input ppp_op_t k, input logic [7:0] d);
        int n;
        opKind <= k;
        opData <= d;
        opValid <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (opReady !== 1'b1 && n < 500);
        if (n >= 500) fail("op not taken");
        opValid <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    // wait until programmer idle and device ready
    task automatic wait_idle();
        int n;
        n = 0;
        while (!(opReady === 1'b1 && pins.ready_busy_out === 1'b1) &&
               n < 500) begin
            @(posedge clock);
            n++;
        end
        if (n >= 500) fail("never idle");
    endtask
    task automatic peek(input logic [4:0] a);
        peekAddr <= a;
        repeat (3) @(posedge clock);
    endtask
    // erase, then check flash blank and eeprom per fuse
    task automatic erase_check(input logic keep);
        fuseKeep <= keep;
        do_op(PPP_OP_CMD, `PPP_CMD_ERASE);
        do_op(PPP_OP_WRITE, 8'h00);
        wait_idle();
        cmp8(commandReg, `PPP_CMD_ERASE);
        if (!keep) eeExp = `PPP_ERASED_BYTE;
        for (i = 0; i < 32; i++) begin
            peek(5'(i));
            cmp16(peekFlash, `PPP_ERASED_WORD);
            cmp8(peekEeprom, eeExp);
        end
    endtask
    // clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge clock);
        fail("timeout");
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        opValid = 1'b0;
        opKind = PPP_OP_CMD;
        opData = 8'h00;
        fuseKeep = 1'b0;
        peekAddr = 5'h00;
        eeExp = `PPP_EE_INIT;
        bad_count = 0;
        checks = 0;
        void'($urandom(32'h2D89523C));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        cmp8(commandReg, 8'h00);
        cmp8(addrLow, 8'h00);
        cmp8({7'h00, pins.ready_busy_out}, 8'h01);
        erase_check(1'b1);
        // page session, high address bits set as corner
        base = 5'($urandom_range(28, 0));
        do_op(PPP_OP_CMD, `PPP_CMD_WRFLASH);
        do_op(PPP_OP_ADDR, {3'h7, base});
        for (i = 0; i < 4; i++) begin
            words[i] = (i == 0) ? 16'hFF00 : 16'($urandom);
            do_op(PPP_OP_DLO, words[i][7:0]);
            do_op(PPP_OP_DHI, words[i][15:8]);
            do_op(PPP_OP_LATCH, 8'h00);
        end
        wait_idle();
        cmp8(commandReg, `PPP_CMD_WRFLASH);
        cmp8(addrLow, {3'h7, base});
        for (i = 0; i < 4; i++) begin
            peek(base + 5'(i));
            cmp16(peekFlash, `PPP_ERASED_WORD);
        end
        do_op(PPP_OP_WRITE, 8'h00);
        wait_idle();
        for (i = 0; i < 4; i++) begin
            peek(base + 5'(i));
            cmp16(peekFlash, words[i]);
        end
        erase_check(1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
